// >>> hdl/srad_consts.vh
// Purpose: constants for the serial receiver with address detect
// Assumes: register byte address is four times the register index
// Notes:   definitions only
`ifndef SRAD_CONSTS_VH
`define SRAD_CONSTS_VH

// register indices (byte address = index * 4)
`define SRAD_IDX_INTERRUPT_FLAGS    8'h0C
`define SRAD_IDX_RECEIVE_CONTROL    8'h18
`define SRAD_IDX_RECEIVE_BUFFER     8'h1A
`define SRAD_IDX_INTERRUPT_ENABLES  8'h8C
`define SRAD_IDX_TRANSMIT_CONTROL   8'h98
`define SRAD_IDX_BAUD_DIVISOR       8'h99

// serial_receive_control fields
`define SRAD_RC_PORT_EN     7
`define SRAD_RC_NINE_BIT    6
`define SRAD_RC_SINGLE      5
`define SRAD_RC_CONT        4
`define SRAD_RC_ADDR_DET    3
`define SRAD_RC_FRAME_ERR   2
`define SRAD_RC_OVERRUN     1
`define SRAD_RC_NINTH       0

// serial_transmit_control fields
`define SRAD_TC_CLK_MASTER  7
`define SRAD_TC_TX_NINE     6
`define SRAD_TC_TX_EN       5
`define SRAD_TC_SYNC        4
`define SRAD_TC_HIGH_SPEED  2
`define SRAD_TC_SHIFT_EMPTY 1
`define SRAD_TC_TX_NINTH    0

// interrupt_flags / interrupt_enables field
`define SRAD_IF_RECEIVE     5

// reset values
`define SRAD_RST_BYTE       8'h00
`define SRAD_RST_TXCTL      8'h02
// transmit shift register empty: this block has no transmitter, so it always reads one
`define SRAD_RST_TXCTL_TRMT 1'b1

// oversampling: last of the sixteen ticks in a bit and the tick at mid start bit
`define SRAD_OVS_LAST       4'hF
`define SRAD_OVS_MID        4'h7

`endif

// >>> hdl/srad_receiver.v
// Purpose: receive side of a serial port with nine-bit address detect
// Assumes: AHB-Lite slave, single whole-word transfers, pins synchronous to clk_i
// Notes:   transmitter datapath lives outside; it reports tx_active_i
//
// Operation
// - nine-bit option captures nine bits; ninth bit goes to status
// - address detect needs address-detect bit and nine-bit option both set
// - with detect active, flag raised and frame kept only if ninth bit is one
// - with detect active, data frames are dropped after stop: no load, no flag
// - a later frame overwrites an ignored frame in the shift register
// - address-detect bit ignored when nine-bit mode is off
// - detect inactive: every frame loaded, ninth bit passed unchanged
// - after software clears detect, frames load whatever their ninth bit
// - continuous reception starts when continuous-receive enable is set
// - clearing continuous-receive enable clears the overrun error
// - receive flag set on completion; interrupt only when enabled
// - address detect works async and sync; sync starts by either enable
// - high-speed bit picks faster async scaling; divisor sets bit rate
// - mode bit set selects synchronous, clear selects asynchronous
// - port enable assigns the pins to clock line and data line
// - in sync mode, clock-source bit makes device master driving the clock line
// - sync master is half duplex: receive and transmit exclude each other
// - two-entry buffer queue carries ninth bit and framing error
// - full queue at third stop sets overrun, drops frame, blocks loads
// - framing error set when stop bit sampled as zero
// - receive flag read-only, cleared when buffer read and empty
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "srad_consts.vh"

module srad_receiver
(
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire        hready_i,
  input  wire [31:0] hwdata_i,
  output wire [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  input  wire        serial_clock_line_i,
  output wire        serial_clock_line_o,
  output wire        serial_clock_line_oe_o,
  input  wire        serial_data_line_i,
  output wire        serial_data_line_o,
  output wire        serial_data_line_oe_o,
  input  wire        tx_active_i,
  output wire        rx_active_o,
  output wire        rx_irq_o
);

  localparam [1:0] S_IDLE  = 2'd0;
  localparam [1:0] S_START = 2'd1;
  localparam [1:0] S_DATA  = 2'd2;
  localparam [1:0] S_STOP  = 2'd3;

  // divider reload: sync 2(n+1), async fast (n+1), async slow 4(n+1) per x16 tick
  function [9:0] brg_limit;
    input       sync;
    input       high_speed;
    input [7:0] div;
    begin
      if (sync)
        brg_limit = {1'b0, div, 1'b1};
      else if (high_speed)
        brg_limit = {2'b00, div};
      else
        brg_limit = {div, 2'b11};
    end
  endfunction

  // control registers
  reg        port_en_q, nine_bit_q, single_q, cont_q, addr_det_q, overrun_error_q;
  reg        clk_master_q, tx_nine_q, tx_en_q, sync_q, high_speed_q, tx_ninth_q;
  reg [7:0]  irq_en_q;
  reg [7:0]  baud_div_q;

  // receive buffer queue: {framing error, ninth bit, byte}
  reg [9:0]  fifo_q [0:1];
  reg        rd_ptr_q;
  reg [1:0]  cnt_q;

  // receiver
  reg [1:0]  st_q;
  reg [3:0]  tcnt_q;
  reg [3:0]  bcnt_q;
  reg [8:0]  rsr_q;
  reg        dt_prev_q;
  reg        ck_prev_q;
  reg        sck_q;
  reg [9:0]  brg_cnt_q;

  // bus
  reg        wr_q;
  reg [7:0]  widx_q;
  reg [31:0] hrdata_q;

  wire       rx_enabled, rx_run, brg_hit, tick, sync_master, samp, last_bit, addr_active;
  wire       acc, rd_acc, mapped, pop, push;
  wire [3:0] last_idx;
  wire [7:0] ridx;
  wire [9:0] head;

  reg        done;
  reg [8:0]  frame;
  reg        frame_framing_error;
  reg        accept;

  assign sync_master = sync_q & clk_master_q;
  // sync may be started by either enable; async only by continuous enable
  assign rx_enabled  = port_en_q & (sync_q ? (cont_q | single_q) : cont_q);
  assign rx_run      = rx_enabled & ~(sync_master & tx_active_i);
  assign rx_active_o = port_en_q & sync_master & (cont_q | single_q);

  assign brg_hit = (brg_cnt_q == brg_limit(sync_q, high_speed_q, baud_div_q));
  assign tick    = brg_hit & ~sync_q;

  // sync sampling on the falling edge of the line clock
  assign samp = sync_q & rx_run &
                (sync_master ? (sck_q & brg_hit) : (ck_prev_q & ~serial_clock_line_i));

  assign last_idx    = nine_bit_q ? 4'd8 : 4'd7;
  assign last_bit    = (bcnt_q == last_idx);
  assign addr_active = addr_det_q & nine_bit_q;

  // pins: clock line driven only as sync master; data line is never driven here
  assign serial_clock_line_o    = sck_q;
  assign serial_clock_line_oe_o = port_en_q & sync_master;
  assign serial_data_line_o     = 1'b0;
  assign serial_data_line_oe_o  = 1'b0;

  // frame completion and filter
  always @*
  begin
    done       = 1'b0;
    frame      = rsr_q;
    frame_framing_error = 1'b0;
    if (samp && last_bit)
    begin
      done  = 1'b1;
      frame[bcnt_q] = serial_data_line_i;
    end
    else if (!sync_q && rx_run && st_q == S_STOP && tick && tcnt_q == `SRAD_OVS_LAST)
    begin
      done       = 1'b1;
      frame_framing_error = ~serial_data_line_i;
    end
    if (!nine_bit_q)
      frame[8] = 1'b0;
    // only address frames pass while detect is active
    accept = ~addr_active | frame[8];
  end

  assign head = fifo_q[rd_ptr_q];
  assign pop  = rd_acc & (ridx == `SRAD_IDX_RECEIVE_BUFFER) & (cnt_q != 2'd0);
  // loads inhibited while overrun stands
  assign push = done & accept & ~overrun_error_q & ((cnt_q != 2'd2) | pop);

  // receive queue
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      fifo_q[0] <= 10'h000;
      fifo_q[1] <= 10'h000;
      rd_ptr_q  <= 1'b0;
      cnt_q     <= 2'd0;
    end
    else
    begin
      if (push)
        fifo_q[rd_ptr_q ^ cnt_q[0] ^ pop] <= {frame_framing_error, frame};
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'd1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'd1;
    end
  end

  // receiver state machine, baud divider and master clock
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st_q      <= S_IDLE;
      tcnt_q    <= 4'h0;
      bcnt_q    <= 4'h0;
      rsr_q     <= 9'h000;
      dt_prev_q <= 1'b1;
      ck_prev_q <= 1'b0;
      sck_q     <= 1'b0;
      brg_cnt_q <= 10'h000;
    end
    else
    begin
      dt_prev_q <= serial_data_line_i;
      ck_prev_q <= serial_clock_line_i;
      if (!rx_run)
      begin
        // divider held in reset while reception is off
        st_q      <= S_IDLE;
        tcnt_q    <= 4'h0;
        bcnt_q    <= 4'h0;
        sck_q     <= 1'b0;
        brg_cnt_q <= 10'h000;
      end
      else
      begin
        brg_cnt_q <= brg_hit ? 10'h000 : brg_cnt_q + 10'h001;
        if (sync_q)
        begin
          if (sync_master && brg_hit)
            sck_q <= ~sck_q;
          if (samp)
          begin
            rsr_q[bcnt_q] <= serial_data_line_i;
            bcnt_q        <= last_bit ? 4'h0 : bcnt_q + 4'h1;
          end
        end
        else
        begin
          case (st_q)
            S_IDLE:
            begin
              if (dt_prev_q && !serial_data_line_i)
              begin
                st_q      <= S_START;
                tcnt_q    <= 4'h0;
                brg_cnt_q <= 10'h000;
              end
            end
            S_START:
            begin
              if (tick)
              begin
                tcnt_q <= tcnt_q + 4'h1;
                if (tcnt_q == `SRAD_OVS_MID)
                begin
                  // a glitch that is high again at mid start is not a frame
                  st_q   <= serial_data_line_i ? S_IDLE : S_DATA;
                  tcnt_q <= 4'h0;
                  bcnt_q <= 4'h0;
                end
              end
            end
            S_DATA:
            begin
              if (tick)
              begin
                tcnt_q <= tcnt_q + 4'h1;
                if (tcnt_q == `SRAD_OVS_LAST)
                begin
                  rsr_q[bcnt_q] <= serial_data_line_i;
                  bcnt_q        <= bcnt_q + 4'h1;
                  if (last_bit)
                    st_q <= S_STOP;
                end
              end
            end
            S_STOP:
            begin
              if (tick)
              begin
                tcnt_q <= tcnt_q + 4'h1;
                if (tcnt_q == `SRAD_OVS_LAST)
                  st_q <= S_IDLE;
              end
            end
            default:
              st_q <= S_IDLE;
          endcase
        end
      end
    end
  end

  // bus slave: zero wait states, read data registered at the address phase
  assign acc    = hsel_i & hready_i & htrans_i[1];
  assign rd_acc = acc & ~hwrite_i;
  assign mapped = (haddr_i[31:10] == 22'h000000);
  assign ridx   = haddr_i[9:2];

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_q     <= 1'b0;
      widx_q   <= 8'h00;
      hrdata_q <= 32'h00000000;
    end
    else
    begin
      wr_q   <= acc & hwrite_i & mapped;
      widx_q <= ridx;
      if (rd_acc)
      begin
        hrdata_q <= 32'h00000000;
        if (mapped)
        begin
          case (ridx)
            `SRAD_IDX_INTERRUPT_FLAGS:
              hrdata_q[`SRAD_IF_RECEIVE] <= (cnt_q != 2'd0);
            `SRAD_IDX_RECEIVE_CONTROL:
              hrdata_q[7:0] <= {port_en_q, nine_bit_q, single_q, cont_q,
                                addr_det_q, head[9], overrun_error_q, head[8]};
            `SRAD_IDX_RECEIVE_BUFFER:
              hrdata_q[7:0] <= head[7:0];
            `SRAD_IDX_INTERRUPT_ENABLES:
              hrdata_q[7:0] <= irq_en_q;
            `SRAD_IDX_TRANSMIT_CONTROL:
              hrdata_q[7:0] <= {clk_master_q, tx_nine_q, tx_en_q, sync_q, 1'b0,
                                high_speed_q, `SRAD_RST_TXCTL_TRMT, tx_ninth_q};
            `SRAD_IDX_BAUD_DIVISOR:
              hrdata_q[7:0] <= baud_div_q;
            default:
              hrdata_q <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // software-visible control registers
  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      {port_en_q, nine_bit_q, single_q, cont_q, addr_det_q} <= 5'h00;
      {clk_master_q, tx_nine_q, tx_en_q, sync_q}           <= 4'h0;
      high_speed_q <= 1'b0;
      tx_ninth_q   <= 1'b0;
      irq_en_q     <= `SRAD_RST_BYTE;
      baud_div_q   <= `SRAD_RST_BYTE;
      overrun_error_q       <= 1'b0;
    end
    else
    begin
      if (done && accept && !overrun_error_q && cnt_q == 2'd2 && !pop)
        overrun_error_q <= 1'b1;
      else if (!cont_q)
        overrun_error_q <= 1'b0;
      // single receive ends itself after one sync word
      if (samp && last_bit && !cont_q)
        single_q <= 1'b0;
      if (wr_q)
      begin
        case (widx_q)
          `SRAD_IDX_RECEIVE_CONTROL:
          begin
            port_en_q  <= hwdata_i[`SRAD_RC_PORT_EN];
            nine_bit_q <= hwdata_i[`SRAD_RC_NINE_BIT];
            single_q   <= hwdata_i[`SRAD_RC_SINGLE];
            cont_q     <= hwdata_i[`SRAD_RC_CONT];
            addr_det_q <= hwdata_i[`SRAD_RC_ADDR_DET];
          end
          `SRAD_IDX_INTERRUPT_ENABLES:
            irq_en_q <= hwdata_i[7:0];
          `SRAD_IDX_TRANSMIT_CONTROL:
          begin
            clk_master_q <= hwdata_i[`SRAD_TC_CLK_MASTER];
            tx_nine_q    <= hwdata_i[`SRAD_TC_TX_NINE];
            tx_en_q      <= hwdata_i[`SRAD_TC_TX_EN];
            sync_q       <= hwdata_i[`SRAD_TC_SYNC];
            high_speed_q <= hwdata_i[`SRAD_TC_HIGH_SPEED];
            tx_ninth_q   <= hwdata_i[`SRAD_TC_TX_NINTH];
          end
          `SRAD_IDX_BAUD_DIVISOR:
            baud_div_q <= hwdata_i[7:0];
          default:
            baud_div_q <= baud_div_q;
        endcase
      end
    end
  end

  assign rx_irq_o    = (cnt_q != 2'd0) & irq_en_q[`SRAD_IF_RECEIVE];
  assign hrdata_o    = hrdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

endmodule

// >>> test/srad_receiver_chk.sv
// Purpose: port-level checks for the serial receiver
// Assumes: word accesses, byte address is four times the register index
// Notes:   shadows the enable bits it needs from observed bus writes
`timescale 1ns/1ps
`include "srad_consts.vh"

module srad_receiver_chk
(
  input wire        clk_i,
  input wire        srst_i,
  input wire        hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire        hready_i,
  input wire [31:0] hwdata_i,
  input wire [31:0] hrdata_o,
  input wire        hreadyout_o,
  input wire        hresp_o,
  input wire        serial_clock_line_o,
  input wire        serial_clock_line_oe_o,
  input wire        serial_data_line_oe_o,
  input wire        rx_active_o,
  input wire        rx_irq_o
);
  reg       wr_q;
  reg       rd_q;
  reg [7:0] idx_q;
  reg       ie_q;
  reg [2:0] mode_q;
  wire      ap = hsel_i & hready_i & htrans_i[1];
  wire      pop_ap = ap & ~hwrite_i & (haddr_i[9:2] == `SRAD_IDX_RECEIVE_BUFFER);
  wire      drv_exp = &mode_q;

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      idx_q  <= 8'h00;
      ie_q   <= 1'b0;
      mode_q <= 3'h0;
    end
    else
    begin
      if (hready_i)
      begin
        wr_q  <= ap & hwrite_i;
        rd_q  <= ap & ~hwrite_i;
        idx_q <= haddr_i[9:2];
      end
      if (wr_q & hready_i & (idx_q == `SRAD_IDX_INTERRUPT_ENABLES))
        ie_q <= hwdata_i[`SRAD_IF_RECEIVE];
      if (wr_q & hready_i & (idx_q == `SRAD_IDX_RECEIVE_CONTROL))
        mode_q[0] <= hwdata_i[`SRAD_RC_PORT_EN];
      if (wr_q & hready_i & (idx_q == `SRAD_IDX_TRANSMIT_CONTROL))
        mode_q[2:1] <= {hwdata_i[`SRAD_TC_CLK_MASTER], hwdata_i[`SRAD_TC_SYNC]};
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  AST_IRQ_NEEDS_ENABLE:
    assert property (rx_irq_o |-> ie_q || $past(ie_q)) else $error("irq without enable");
  AST_IRQ_SHOWS_FLAG:
    assert property (rd_q && idx_q == `SRAD_IDX_INTERRUPT_FLAGS && ie_q && $past(ie_q, 2)
      |-> hrdata_o[5] == $past(rx_irq_o)) else $error("flag read differs from irq");
  AST_FLAG_HELD:
    assert property ($fell(rx_irq_o) && ie_q && $past(ie_q) |-> $past(pop_ap) || $past(pop_ap, 2))
      else $error("flag dropped without buffer read");
  AST_CLOCK_DRIVE:
    assert property (drv_exp == $past(drv_exp) |-> serial_clock_line_oe_o == drv_exp)
      else $error("clock line drive wrong");
  AST_RX_ACTIVE_MASTER:
    assert property (rx_active_o |-> serial_clock_line_oe_o || $past(serial_clock_line_oe_o))
      else $error("receive active outside master mode");
  AST_DATA_RELEASED:
    assert property (!serial_data_line_oe_o) else $error("receiver drives data line");
  AST_CLOCK_IDLE_LOW:
    assert property (!serial_clock_line_oe_o && !$past(serial_clock_line_oe_o)
      |-> !serial_clock_line_o) else $error("clock line output moves while not driven");
  AST_BUS_OKAY:
    assert property (hreadyout_o && !hresp_o) else $error("bus wait or error response");
  AST_UPPER_ZERO:
    assert property (rd_q |-> hrdata_o[31:8] == 24'h000000) else $error("upper read bits set");
endmodule

bind srad_receiver srad_receiver_chk chk_u
(
  .clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hwdata_i(hwdata_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .serial_clock_line_o(serial_clock_line_o),
  .serial_clock_line_oe_o(serial_clock_line_oe_o),
  .serial_data_line_oe_o(serial_data_line_oe_o),
  .rx_active_o(rx_active_o), .rx_irq_o(rx_irq_o)
);

// >>> test/srad_line_peer.sv
// Purpose: far-side processor sending asynchronous frames
// Assumes: line idles high; bit time given in clocks per call
// Notes:   stop level may be forced low to make a framing fault
`timescale 1ns/1ps

module srad_line_peer
(
  input wire clk_i,
  output reg line_o
);
  initial line_o = 1'b1;

  task send(input [8:0] word, input nine, input stop_lvl, input integer bit_clks);
    integer i;
    begin
      line_o <= 1'b0;
      repeat (bit_clks) @(posedge clk_i);
      for (i = 0; i < (nine ? 9 : 8); i = i + 1)
      begin
        line_o <= word[i];
        repeat (bit_clks) @(posedge clk_i);
      end
      line_o <= stop_lvl;
      repeat (bit_clks) @(posedge clk_i);
      line_o <= 1'b1;
      repeat (bit_clks) @(posedge clk_i);
    end
  endtask
endmodule

// >>> test/testbench.sv
// Purpose: register-level test of the serial receiver with address detect
// Assumes: divisor 0; fast scaling gives sixteen clocks per bit
// Notes:   tasks are entered just after a rising edge
`timescale 1ns/1ps
`include "srad_consts.vh"

module testbench;
  reg         clk_i = 1'b0;
  reg         srst_i = 1'b1;
  reg         hsel_i = 1'b0;
  reg  [31:0] haddr_i = 32'h00000000;
  reg  [1:0]  htrans_i = 2'b00;
  reg         hwrite_i = 1'b0;
  reg  [31:0] hwdata_i = 32'h00000000;
  reg         tx_active_i = 1'b0;
  wire [31:0] hrdata_o;
  wire        hreadyout_o, hresp_o, ck_o, ck_oe, dt_o, dt_oe, line, rx_active_o, rx_irq_o;
  integer     n_mismatch = 0;
  integer     comparisons = 0;
  integer     cycles = 0;
  integer     bit_clks = 16;
  integer     i;
  reg  [7:0]  rd;

  always #20 clk_i = ~clk_i;

  srad_receiver dut_u
  (
    .clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'b010), .hready_i(hreadyout_o),
    .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .serial_clock_line_i(ck_oe ? ck_o : 1'b0), .serial_clock_line_o(ck_o),
    .serial_clock_line_oe_o(ck_oe), .serial_data_line_i(dt_oe ? dt_o : line),
    .serial_data_line_o(dt_o), .serial_data_line_oe_o(dt_oe),
    .tx_active_i(tx_active_i), .rx_active_o(rx_active_o), .rx_irq_o(rx_irq_o)
  );

  srad_line_peer peer_u
  (
    .clk_i(clk_i), .line_o(line)
  );

  task wrap_up;
    begin
      if (n_mismatch == 0 && comparisons > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task bus(input wr, input [7:0] idx, input [7:0] wd);
    begin
      hsel_i   <= 1'b1;
      htrans_i <= 2'b10;
      hwrite_i <= wr;
      haddr_i  <= {22'h000000, idx, 2'b00};
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      hsel_i   <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= {24'h000000, wd};
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o[7:0];
    end
  endtask

  task cmp(input [7:0] act, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (act !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR t=%0t got %h expected %h", $time, act, exp);
      end
    end
  endtask

  task check(input [7:0] idx, input [7:0] exp);
    begin
      bus(1'b0, idx, 8'h00);
      cmp(rd, exp);
    end
  endtask

  task frame(input [8:0] w, input nine, input stop);
    begin
      peer_u.send(w, nine, stop, bit_clks);
    end
  endtask

  always @(posedge clk_i)
  begin
    cycles = cycles + 1;
    if (cycles == 60000)
    begin
      n_mismatch = n_mismatch + 1;
      wrap_up;
    end
  end

  initial
  begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    check(`SRAD_IDX_INTERRUPT_FLAGS, 8'h00);
    check(`SRAD_IDX_RECEIVE_CONTROL, 8'h00);
    check(`SRAD_IDX_RECEIVE_BUFFER, 8'h00);
    check(`SRAD_IDX_INTERRUPT_ENABLES, 8'h00);
    check(`SRAD_IDX_TRANSMIT_CONTROL, 8'h02);
    check(`SRAD_IDX_BAUD_DIVISOR, 8'h00);
    bus(1'b1, 8'h10, 8'hFF);
    check(8'h10, 8'h00);
    bus(1'b1, `SRAD_IDX_INTERRUPT_FLAGS, 8'hFF);
    check(`SRAD_IDX_INTERRUPT_FLAGS, 8'h00);
    bus(1'b1, `SRAD_IDX_TRANSMIT_CONTROL, 8'h04);
    check(`SRAD_IDX_TRANSMIT_CONTROL, 8'h06);
    bus(1'b1, `SRAD_IDX_INTERRUPT_ENABLES, 8'h20);
    bus(1'b1, `SRAD_IDX_RECEIVE_CONTROL, 8'h90);
    frame(9'h05A, 1'b0, 1'b1);
    cmp({7'h00, rx_irq_o}, 8'h01);
    bus(1'b1, `SRAD_IDX_INTERRUPT_ENABLES, 8'h00);
    check(`SRAD_IDX_INTERRUPT_FLAGS, 8'h20);
    cmp({7'h00, rx_irq_o}, 8'h00);
    bus(1'b1, `SRAD_IDX_INTERRUPT_ENABLES, 8'h20);
    check(`SRAD_IDX_RECEIVE_CONTROL, 8'h90);
    check(`SRAD_IDX_RECEIVE_BUFFER, 8'h5A);
    check(`SRAD_IDX_INTERRUPT_FLAGS, 8'h00);
    bus(1'b1, `SRAD_IDX_RECEIVE_CONTROL, 8'h98);
    frame(9'h033, 1'b0, 1'b1);
    check(`SRAD_IDX_RECEIVE_BUFFER, 8'h33);
    bus(1'b1, `SRAD_IDX_RECEIVE_CONTROL, 8'hD0);
    frame(9'h0A5, 1'b1, 1'b1);
    frame(9'h1C3, 1'b1, 1'b1);
    check(`SRAD_IDX_RECEIVE_CONTROL, 8'hD0);
    check(`SRAD_IDX_RECEIVE_BUFFER, 8'hA5);
    check(`SRAD_IDX_RECEIVE_CONTROL, 8'hD1);
    check(`SRAD_IDX_RECEIVE_BUFFER, 8'hC3);
    bus(1'b1, `SRAD_IDX_RECEIVE_CONTROL, 8'hD8);
    frame(9'h011, 1'b1, 1'b1);
    check(`SRAD_IDX_INTERRUPT_FLAGS, 8'h00);
    frame(9'h17E, 1'b1, 1'b1);
    check(`SRAD_IDX_RECEIVE_CONTROL, 8'hD9);
    check(`SRAD_IDX_RECEIVE_BUFFER, 8'h7E);
    check(`SRAD_IDX_INTERRUPT_FLAGS, 8'h00);
    bus(1'b1, `SRAD_IDX_RECEIVE_CONTROL, 8'hD0);
    frame(9'h022, 1'b1, 1'b1);
    check(`SRAD_IDX_RECEIVE_BUFFER, 8'h22);
    frame(9'h144, 1'b1, 1'b0);
    check(`SRAD_IDX_RECEIVE_CONTROL, 8'hD5);
    check(`SRAD_IDX_RECEIVE_BUFFER, 8'h44);
    bus(1'b1, `SRAD_IDX_RECEIVE_CONTROL, 8'h90);
    for (i = 1; i < 4; i = i + 1)
      frame(i[8:0], 1'b0, 1'b1);
    check(`SRAD_IDX_RECEIVE_CONTROL, 8'h92);
    check(`SRAD_IDX_RECEIVE_BUFFER, 8'h01);
    check(`SRAD_IDX_RECEIVE_BUFFER, 8'h02);
    frame(9'h004, 1'b0, 1'b1);
    check(`SRAD_IDX_INTERRUPT_FLAGS, 8'h00);
    bus(1'b1, `SRAD_IDX_RECEIVE_CONTROL, 8'h80);
    // overrun clears on the edge after the enable is seen low
    @(posedge clk_i);
    check(`SRAD_IDX_RECEIVE_CONTROL, 8'h80);
    frame(9'h005, 1'b0, 1'b1);
    check(`SRAD_IDX_INTERRUPT_FLAGS, 8'h00);
    bus(1'b1, `SRAD_IDX_RECEIVE_CONTROL, 8'h90);
    bus(1'b1, `SRAD_IDX_TRANSMIT_CONTROL, 8'h00);
    bit_clks = 64;
    frame(9'h0C9, 1'b0, 1'b1);
    check(`SRAD_IDX_RECEIVE_BUFFER, 8'hC9);
    tx_active_i <= 1'b1;
    bus(1'b1, `SRAD_IDX_TRANSMIT_CONTROL, 8'h90);
    check(`SRAD_IDX_TRANSMIT_CONTROL, 8'h92);
    cmp({7'h00, ck_oe}, 8'h01);
    cmp({7'h00, rx_active_o}, 8'h01);
    repeat (200) @(posedge clk_i);
    check(`SRAD_IDX_INTERRUPT_FLAGS, 8'h00);
    tx_active_i <= 1'b0;
    repeat (64) @(posedge clk_i);
    check(`SRAD_IDX_INTERRUPT_FLAGS, 8'h20);
    check(`SRAD_IDX_RECEIVE_BUFFER, 8'hFF);
    bus(1'b1, `SRAD_IDX_RECEIVE_CONTROL, 8'h00);
    bus(1'b1, `SRAD_IDX_RECEIVE_CONTROL, 8'hA0);
    repeat (64) @(posedge clk_i);
    check(`SRAD_IDX_RECEIVE_CONTROL, 8'h80);
    check(`SRAD_IDX_RECEIVE_BUFFER, 8'hFF);
    check(`SRAD_IDX_RECEIVE_BUFFER, 8'hFF);
    check(`SRAD_IDX_INTERRUPT_FLAGS, 8'h00);
    bus(1'b1, `SRAD_IDX_RECEIVE_CONTROL, 8'h00);
    check(`SRAD_IDX_BAUD_DIVISOR, 8'h00);
    cmp({7'h00, ck_oe}, 8'h00);
    wrap_up;
  end
endmodule
